// >>> pkg/uart_cal_pkg.sv
// Constants for the calibrated-rate serial transceiver: register map, fields, rates.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone slave port.
package uart_cal_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int MAX_BPS = 115200;
    localparam int OVERSAMPLE = 16;
    // Register byte offsets.
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_PRESC = 8'h0C;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    // Command register fields.
    localparam int CMD_RXIE = 0;
    localparam int CMD_TXIE = 1;
    localparam int CMD_PAREN = 2;
    localparam int CMD_PARODD = 3;
    localparam int CMD_AUTOCAL = 4;
    localparam logic [4:0] CMD_RESET = 5'h10;
    // Status register fields.
    localparam int ST_RX = 0;
    localparam int ST_TX = 1;
    localparam int ST_FRAME = 2;
    localparam int ST_OVER = 3;
    localparam int ST_PARITY = 4;
    localparam int ST_RXFULL = 5;
    localparam int ST_TXBUSY = 6;
    localparam logic [4:0] STICKY_MASK = 5'h1F;
    localparam logic [3:0] BAUD_RESET = 4'h3;
    localparam logic [15:0] PRESC_RESET = 16'h0035;
    localparam int NUM_RATES = 10;
    // Build option: when zero, the transmit pin becomes general port bit four; port bit five is never read.
    localparam logic SERIAL_USED = 1'b1;

    // Count limit for one oversample tick: CLK_HZ / (16 * rate), rounded down, minus one.
    function automatic logic [15:0] rate_div(input logic [3:0] sel);
        int bps;
        case (sel)
            4'h0: bps = 1200;
            4'h1: bps = 2400;
            4'h2: bps = 4800;
            4'h3: bps = 9600;
            4'h4: bps = 19200;
            4'h5: bps = 38400;
            4'h6: bps = 51200;
            4'h7: bps = 57600;
            4'h8: bps = 102400;
            default: bps = MAX_BPS;
        endcase
        return 16'(CLK_HZ / (OVERSAMPLE * bps) - 1);
    endfunction
endpackage

// >>> hdl/uart_autocal_baud.sv
// Single-channel UART with a Wishbone register file and a sticky interrupt block.
// Assumes one 100 MHz clock; the receive pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
module uart_autocal_baud (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic IRQ,
    input wire logic RXD,
    output logic TXD,
    input wire logic PORT_EF_BIT_FIVE_I,
    output logic PORT_EF_BIT_FOUR_O,
    output logic PORT_EF_BIT_FOUR_OE
);
    import uart_cal_pkg::*;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

    logic [4:0] cmd_reg, cmd_next;
    logic [3:0] baud_reg, baud_next;
    logic [15:0] presc_reg, presc_next;
    logic [4:0] stat_reg, stat_next;
    logic [4:0] mask_reg, mask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [15:0] div_reg, div_next;
    logic tick;
    logic [2:0] rx_sync_reg;
    logic rx_line_reg, rx_line_next;
    tx_state_e tx_st_reg, tx_st_next;
    logic [3:0] tx_os_reg, tx_os_next;
    logic [2:0] tx_bit_reg, tx_bit_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic tx_par_reg, tx_par_next;
    logic txd_reg, txd_next;
    logic tx_pend_reg, tx_pend_next;
    logic [7:0] tx_hold_reg, tx_hold_next;
    logic tx_done;
    rx_state_e rx_st_reg, rx_st_next;
    logic [3:0] rx_os_reg, rx_os_next;
    logic [2:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic rx_par_reg, rx_par_next;
    logic [7:0] rx_buf_reg, rx_buf_next;
    logic rx_full_reg, rx_full_next;
    logic rx_done, rx_ferr, rx_perr, rx_over;
    logic wb_req, wr_en, rd_en;
    logic [15:0] div_limit;
    logic serial_in;

    assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;
    assign wr_en = wb_req && WB_WE_I && WB_SEL_I[0];
    assign rd_en = wb_req && !WB_WE_I;
    // Calibrated table or free prescaler selects the oversample divisor.
    assign div_limit = cmd_reg[CMD_AUTOCAL] ? rate_div(baud_reg) : presc_reg;
    assign tick = (div_reg >= div_limit);
    // Build option swaps the transmit pin for port bit four and holds the receive input idle high.
    assign serial_in = SERIAL_USED ? rx_line_reg : 1'b1;

    // Registers and bus answer.
    always_comb begin
        cmd_next = cmd_reg;
        baud_next = baud_reg;
        presc_next = presc_reg;
        mask_next = mask_reg;
        ack_next = wb_req;
        rdat_next = rdat_reg;
        stat_next = stat_reg;
        if (wr_en) begin
            case (WB_ADR_I)
                OFF_CMD: cmd_next = WB_DAT_I[4:0];
                OFF_BAUD: baud_next = (WB_DAT_I[3:0] < 4'(NUM_RATES)) ? WB_DAT_I[3:0] : 4'h9;
                OFF_PRESC: presc_next = WB_DAT_I[15:0];
                OFF_MASK: mask_next = WB_DAT_I[4:0];
                OFF_STAT: stat_next = stat_reg & ~WB_DAT_I[4:0];
                default: ;
            endcase
        end
        // Setting wins over a simultaneous write-one-to-clear.
        stat_next[ST_RX] = stat_next[ST_RX] | rx_done;
        stat_next[ST_TX] = stat_next[ST_TX] | tx_done;
        stat_next[ST_FRAME] = stat_next[ST_FRAME] | rx_ferr;
        stat_next[ST_OVER] = stat_next[ST_OVER] | rx_over;
        stat_next[ST_PARITY] = stat_next[ST_PARITY] | rx_perr;
        if (rd_en) begin
            case (WB_ADR_I)
                OFF_DATA: rdat_next = {24'h000000, rx_buf_reg};
                OFF_CMD: rdat_next = {27'h0000000, cmd_reg};
                OFF_BAUD: rdat_next = {28'h0000000, baud_reg};
                OFF_PRESC: rdat_next = {16'h0000, presc_reg};
                OFF_STAT: rdat_next = {25'h0000000, tx_pend_reg || tx_st_reg != TX_IDLE, rx_full_reg, stat_reg};
                OFF_MASK: rdat_next = {27'h0000000, mask_reg};
                default: rdat_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_reg <= CMD_RESET;
            baud_reg <= BAUD_RESET;
            presc_reg <= PRESC_RESET;
            mask_reg <= 5'h00;
            stat_reg <= 5'h00;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            cmd_reg <= cmd_next;
            baud_reg <= baud_next;
            presc_reg <= presc_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdat_reg;
    // Receive and transmit events also need their command enable, as well as the mask.
    assign IRQ = |(stat_reg & mask_reg & {3'b111, cmd_reg[CMD_TXIE], cmd_reg[CMD_RXIE]});

    // Oversample divider and input synchroniser; the receive line counts once stages two and three agree.
    always_comb begin
        div_next = tick ? 16'h0000 : div_reg + 16'h0001;
        rx_line_next = (rx_sync_reg[1] == rx_sync_reg[2]) ? rx_sync_reg[2] : rx_line_reg;
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_reg <= 16'h0000;
            rx_sync_reg <= 3'b111;
            rx_line_reg <= 1'b1;
        end else begin
            div_reg <= div_next;
            rx_sync_reg <= {rx_sync_reg[1:0], RXD};
            rx_line_reg <= rx_line_next;
        end
    end

    // Transmitter: one holding byte plus the shifter, so one write during a frame is not lost; a write while the holding byte is full is ignored.
    always_comb begin
        tx_st_next = tx_st_reg;
        tx_os_next = tx_os_reg;
        tx_bit_next = tx_bit_reg;
        tx_sh_next = tx_sh_reg;
        tx_par_next = tx_par_reg;
        txd_next = txd_reg;
        tx_pend_next = tx_pend_reg;
        tx_hold_next = tx_hold_reg;
        tx_done = 1'b0;
        if (wr_en && WB_ADR_I == OFF_DATA && !tx_pend_reg) begin
            tx_pend_next = 1'b1;
            tx_hold_next = WB_DAT_I[7:0];
        end
        if (tick) begin
            tx_os_next = tx_os_reg + 4'h1;
            case (tx_st_reg)
                TX_IDLE: begin
                    txd_next = 1'b1;
                    if (tx_pend_reg) begin
                        tx_pend_next = 1'b0;
                        tx_sh_next = tx_hold_reg;
                        tx_par_next = cmd_reg[CMD_PARODD];
                        tx_os_next = 4'h0;
                        txd_next = 1'b0;
                        tx_st_next = TX_START;
                    end
                end
                TX_START, TX_DATA, TX_PAR: begin
                    if (tx_os_reg == 4'hF) begin
                        if (tx_st_reg == TX_START) begin
                            tx_bit_next = 3'h0;
                            txd_next = tx_sh_reg[0];
                            tx_st_next = TX_DATA;
                        end else if (tx_st_reg == TX_DATA) begin
                            tx_par_next = tx_par_reg ^ tx_sh_reg[0];
                            tx_sh_next = {1'b0, tx_sh_reg[7:1]};
                            tx_bit_next = tx_bit_reg + 3'h1;
                            if (tx_bit_reg == 3'h7) begin
                                txd_next = cmd_reg[CMD_PAREN] ? tx_par_reg ^ tx_sh_reg[0] : 1'b1;
                                tx_st_next = cmd_reg[CMD_PAREN] ? TX_PAR : TX_STOP;
                            end else begin
                                txd_next = tx_sh_reg[1];
                            end
                        end else begin
                            txd_next = 1'b1;
                            tx_st_next = TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_os_reg == 4'hF) begin
                        tx_done = 1'b1;
                        tx_st_next = TX_IDLE;
                    end
                end
                default: tx_st_next = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_st_reg <= TX_IDLE;
            tx_os_reg <= 4'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= 8'h00;
            tx_par_reg <= 1'b0;
            txd_reg <= 1'b1;
            tx_pend_reg <= 1'b0;
            tx_hold_reg <= 8'h00;
        end else begin
            tx_st_reg <= tx_st_next;
            tx_os_reg <= tx_os_next;
            tx_bit_reg <= tx_bit_next;
            tx_sh_reg <= tx_sh_next;
            tx_par_reg <= tx_par_next;
            txd_reg <= txd_next;
            tx_pend_reg <= tx_pend_next;
            tx_hold_reg <= tx_hold_next;
        end
    end

    assign TXD = SERIAL_USED ? txd_reg : 1'b1;
    assign PORT_EF_BIT_FOUR_O = SERIAL_USED ? 1'b0 : tx_hold_reg[0];
    assign PORT_EF_BIT_FOUR_OE = !SERIAL_USED;

    // Receiver checks the start bit mid-bit at count 7, then samples each later bit mid-bit at count 15 of 16 oversample ticks.
    always_comb begin
        rx_st_next = rx_st_reg;
        rx_os_next = rx_os_reg;
        rx_bit_next = rx_bit_reg;
        rx_sh_next = rx_sh_reg;
        rx_par_next = rx_par_reg;
        rx_buf_next = rx_buf_reg;
        rx_full_next = rx_full_reg;
        rx_done = 1'b0;
        rx_ferr = 1'b0;
        rx_perr = 1'b0;
        rx_over = 1'b0;
        if (rd_en && WB_ADR_I == OFF_DATA) begin
            rx_full_next = 1'b0;
        end
        if (tick) begin
            rx_os_next = rx_os_reg + 4'h1;
            case (rx_st_reg)
                RX_IDLE: begin
                    rx_os_next = 4'h0;
                    if (!serial_in) begin
                        rx_st_next = RX_START;
                    end
                end
                RX_START: begin
                    if (rx_os_reg == 4'h7) begin
                        rx_os_next = 4'h0;
                        rx_bit_next = 3'h0;
                        rx_par_next = cmd_reg[CMD_PARODD];
                        // A glitch shorter than half a bit is not a start bit.
                        rx_st_next = serial_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_os_reg == 4'hF) begin
                        rx_sh_next = {serial_in, rx_sh_reg[7:1]};
                        rx_par_next = rx_par_reg ^ serial_in;
                        rx_bit_next = rx_bit_reg + 3'h1;
                        if (rx_bit_reg == 3'h7) begin
                            rx_st_next = cmd_reg[CMD_PAREN] ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_os_reg == 4'hF) begin
                        rx_perr = (rx_par_reg != serial_in);
                        rx_st_next = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_os_reg == 4'hF) begin
                        rx_done = 1'b1;
                        rx_ferr = !serial_in;
                        rx_over = rx_full_reg && !(rd_en && WB_ADR_I == OFF_DATA);
                        rx_buf_next = rx_sh_reg;
                        rx_full_next = 1'b1;
                        rx_st_next = RX_IDLE;
                    end
                end
                default: rx_st_next = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rx_st_reg <= RX_IDLE;
            rx_os_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            rx_par_reg <= 1'b0;
            rx_buf_reg <= 8'h00;
            rx_full_reg <= 1'b0;
        end else begin
            rx_st_reg <= rx_st_next;
            rx_os_reg <= rx_os_next;
            rx_bit_reg <= rx_bit_next;
            rx_sh_reg <= rx_sh_next;
            rx_par_reg <= rx_par_next;
            rx_buf_reg <= rx_buf_next;
            rx_full_reg <= rx_full_next;
        end
    end

    // A divisor lowered under the running count must restart it at once, not after a full wrap.
    a_div_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (div_reg >= div_limit) |=> (div_reg == 16'h0000))
        else $error("oversample divider overran its limit");
    a_tx_done_irq: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        tx_done |=> stat_reg[ST_TX])
        else $error("transmit event not latched");
    a_rx_done_irq: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        rx_done |=> stat_reg[ST_RX] && rx_full_reg)
        else $error("receive event not latched");
    a_frame_err: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (rx_done && !serial_in) |=> stat_reg[ST_FRAME])
        else $error("framing error missed");
    a_overrun: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        rx_over |-> rx_full_reg ##1 stat_reg[ST_OVER])
        else $error("overrun missed");
    a_start_low: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (tx_st_reg == TX_IDLE && tx_st_next == TX_START) |=> !TXD)
        else $error("start bit not low");
    a_stop_high: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (tx_st_reg == TX_STOP) |-> TXD)
        else $error("stop bit not high");
    a_autocal_div: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        cmd_reg[CMD_AUTOCAL] |-> div_limit == rate_div(baud_reg))
        else $error("calibrated divisor wrong");
    a_presc_div: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        !cmd_reg[CMD_AUTOCAL] |-> div_limit == presc_reg)
        else $error("prescaler divisor wrong");
    a_ack_one: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");
endmodule // uart_autocal_baud

// >>> tb/uart_far_end.sv
// Far-end UART model: drives frames onto the receive line and collects frames from the transmit line.
// Assumes the bench sets the bit length in core clocks and the parity settings before any traffic.
`timescale 1ns/1ps
module uart_far_end (
    input wire logic clk,
    input wire logic txd,
    output logic rxd,
    input wire logic [31:0] bit_clks,
    input wire logic par_en,
    input wire logic par_odd
);
    logic [7:0] rx_q[$];
    logic par_bad = 1'b0;
    initial rxd = 1'b1; // The line idles high.

    // Bad parity or a low stop bit is sent only when a test asks for it.
    task automatic send(input logic [7:0] v, input logic bad_par, input logic bad_stop);
        logic [10:0] f;
        int n;
        f = {~bad_stop, (^v) ^ par_odd ^ bad_par, v, 1'b0}; // Start, LSB first, parity, stop.
        n = par_en ? 11 : 10;
        if (!par_en) f[9] = ~bad_stop;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (bit_clks - 1) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask

    // Samples at mid-bit; a frame whose stop bit is low is dropped.
    always begin : catch
        logic [7:0] d;
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge clk);
            d[i] = txd;
        end
        if (par_en) begin
            repeat (bit_clks) @(posedge clk);
            if (txd !== ((^d) ^ par_odd)) par_bad = 1'b1;
        end
        repeat (bit_clks) @(posedge clk);
        if (txd === 1'b1) rx_q.push_back(d);
    end
endmodule // uart_far_end

// >>> tb/uart_autocal_baud_tb_top.sv
// Self-checking bench for the serial transceiver: register bus, interrupts, both directions.
// Assumes the far-end model in uart_far_end and the constants of uart_cal_pkg.
`timescale 1ns/1ps
module uart_autocal_baud_tb_top;
    import uart_cal_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic ack, irq, rxd, txd, ef_o, ef_oe;
    logic [31:0] rd;
    logic [31:0] seed = 32'h0000003F;
    int error_cnt = 0;
    int tests_run = 0;
    int bit_clks = 64;
    logic par_en = 1'b0;
    logic par_odd = 1'b0;

    always #5 clk = ~clk;

    uart_autocal_baud uut (.CORE_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .IRQ(irq),
        .RXD(rxd), .TXD(txd), .PORT_EF_BIT_FIVE_I(1'b0), .PORT_EF_BIT_FOUR_O(ef_o), .PORT_EF_BIT_FOUR_OE(ef_oe));
    uart_far_end far (.clk(clk), .txd(txd), .rxd(rxd), .bit_clks(bit_clks), .par_en(par_en), .par_odd(par_odd));

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Bit time in core clocks for a calibrated rate: the tick divisor rounds down.
    function automatic int rate_clks(input int bps);
        return OVERSAMPLE * (CLK_HZ / (OVERSAMPLE * bps));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One classic cycle; read data lands in rd at the edge that samples ack.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat_w <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) chk({31'h0, ack}, 32'h1);
    endtask

    // The first byte is in the shifter after one bit time, so the second write is held and the third,
    // landing while that held byte still waits, must be ignored.
    task automatic tx_one(input logic [7:0] v);
        int n;
        n = 0;
        wb(1'b1, OFF_DATA, {24'h0, v});
        repeat (bit_clks) @(posedge clk);
        wb(1'b1, OFF_DATA, {24'h0, ~v});
        wb(1'b1, OFF_DATA, {24'h0, v});
        do begin
            wb(1'b0, OFF_STAT, 32'h0);
            n++;
        end while (rd[ST_TXBUSY] !== 1'b0 && n < 20000);
        wb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h1);
        chk(far.rx_q.size(), 2);
        if (far.rx_q.size() > 1) begin
            chk({24'h0, far.rx_q.pop_front()}, {24'h0, v});
            chk({24'h0, far.rx_q.pop_front()}, {24'h0, ~v});
        end
        far.rx_q.delete();
        chk({31'h0, far.par_bad}, 32'h0);
        wb(1'b1, OFF_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic rx_one(input logic [7:0] v, input logic bp, input logic bs, input logic [31:0] st,
        input logic [31:0] irq_exp);
        far.send(v, bp, bs);
        repeat (8) @(posedge clk);
        wb(1'b0, OFF_STAT, 32'h0);
        chk(rd, st);
        chk({31'h0, irq}, irq_exp);
        wb(1'b0, OFF_DATA, 32'h0);
        chk(rd, {24'h0, v});
        wb(1'b1, OFF_STAT, 32'h1F);
    endtask

    initial begin
        #900000;
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, OFF_CMD, 32'h0);
        chk(rd, {27'h0, CMD_RESET});
        wb(1'b0, OFF_BAUD, 32'h0);
        chk(rd, {28'h0, BAUD_RESET});
        wb(1'b0, OFF_PRESC, 32'h0);
        chk(rd, {16'h0, PRESC_RESET});
        wb(1'b0, OFF_STAT, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, OFF_MASK, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, txd}, 32'h1);
        chk({30'h0, ef_oe, ef_o}, 32'h0);
        wb(1'b1, OFF_BAUD, 32'hC);
        wb(1'b0, OFF_BAUD, 32'h0);
        chk(rd, 32'h9);
        $display("Test registers done");
        // The prescaler counts the core clock here, so drift is not modelled.
        wb(1'b1, OFF_PRESC, 32'h3);
        wb(1'b1, OFF_MASK, 32'h1F);
        for (int m = 0; m < 4; m++) begin
            par_en = m[0];
            par_odd = m[1];
            wb(1'b1, OFF_CMD, {28'h0, m[1], m[0], 2'b11});
            tx_one(8'(next_rand()));
            rx_one(8'(next_rand()), 1'b0, 1'b0, 32'h21, 32'h1);
        end
        $display("Test prescaler traffic done");
        par_en = 1'b1;
        par_odd = 1'b0;
        wb(1'b1, OFF_CMD, 32'h7);
        rx_one(8'(next_rand()), 1'b1, 1'b0, 32'h31, 32'h1);
        rx_one(8'(next_rand()), 1'b0, 1'b1, 32'h25, 32'h1);
        far.send(8'h00, 1'b0, 1'b0);
        rx_one(8'hFF, 1'b0, 1'b0, 32'h29, 32'h1);
        wb(1'b1, OFF_MASK, 32'h0);
        rx_one(8'h80, 1'b0, 1'b0, 32'h21, 32'h0);
        wb(1'b1, OFF_MASK, 32'h1F);
        $display("Test receive errors done");
        par_en = 1'b0;
        bit_clks = rate_clks(115200);
        wb(1'b1, OFF_CMD, 32'h13);
        tx_one(8'hA5);
        rx_one(8'h5A, 1'b0, 1'b0, 32'h21, 32'h1);
        $display("Test calibrated rate done");
        close_out();
    end
endmodule // uart_autocal_baud_tb_top
